// File: core/jid_pkg.sv
// Constants, state codes and carrier types for the test-port instruction decoder.
// Assumes a single system clock that oversamples the test clock pin.
`default_nettype none
package jid_pkg;
   // Boundary chain: input cells, output cells, output-enable cells
   localparam int NI = 4;
   localparam int NO = 4;
   localparam int BSL = NI + 2 * NO;
   localparam int BS_IN = 0;
   localparam int BS_OUT = NI;
   localparam int BS_EN = NI + NO;
   localparam int IRW = 4;
   localparam int IDW = 32;
   localparam logic [3:0] IR_CAPT = 4'h1;
   localparam logic [3:0] OP_EXTEST = 4'h0;
   localparam logic [3:0] OP_SAMPLE = 4'h3;
   localparam logic [3:0] OP_CLAMP = 4'h5;
   localparam logic [3:0] OP_HIGHZ = 4'h7;
   localparam logic [3:0] OP_CLAMPZ = 4'h9;
   localparam logic [3:0] OP_INTEST = 4'hC;
   localparam logic [3:0] OP_IDCODE = 4'hE;
   localparam logic [3:0] OP_BYPASS = 4'hF;
   typedef enum logic [3:0] {
      TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SDR = 4'h3, TAP_CDR = 4'h2,
      TAP_SHDR = 4'h6, TAP_E1DR = 4'h7, TAP_PDR = 4'h5, TAP_E2DR = 4'h4,
      TAP_UDR = 4'hC, TAP_SIR = 4'hD, TAP_CIR = 4'hF, TAP_SHIR = 4'hE,
      TAP_E1IR = 4'hA, TAP_PIR = 4'hB, TAP_E2IR = 4'h9, TAP_UIR = 4'h8
   } jid_tap_t;
   typedef enum logic [1:0] {SEL_BS = 2'h0, SEL_BYP = 2'h1, SEL_ID = 2'h3} jid_sel_t;
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
   } jid_pins_t;
   localparam jid_pins_t PINS_RST = 4'h6;
endpackage
`default_nettype wire

// File: core/jid_top.sv
// Instruction register, decoder and data registers of a boundary-scan test port.
// Test pins are asynchronous to clk_sys and are oversampled; the test clock must be
// slow enough for two-flop sampling (period well above 4 system clocks).
`default_nettype none
module jid_top #(
   parameter logic [31:0] ID_VALUE = 32'h1000_0001 // Arbitrary identification value
) (
   // System
   input wire logic clk_sys,
   input wire logic rst,
   // Test pins
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_n,
   output logic tdo,
   output logic tdo_oe,
   // Pad side
   input wire logic [jid_pkg::NI-1:0] pin_in,
   output logic [jid_pkg::NO-1:0] pad_out,
   output logic [jid_pkg::NO-1:0] pad_oe,
   // Core side
   output logic [jid_pkg::NI-1:0] core_in,
   input wire logic [jid_pkg::NO-1:0] core_out,
   input wire logic [jid_pkg::NO-1:0] core_oe
);
   jid_pkg::jid_pins_t pins_s1_ff, pins_s2_ff;
   logic [jid_pkg::NI-1:0] pin_s1_ff, pin_s2_ff;
   logic tck_d_ff;
   logic rise, fall;

   // Two-flop sampling of the test pins and pin_in; core_out and core_oe are used unsampled
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pins_s1_ff <= jid_pkg::PINS_RST;
         pins_s2_ff <= jid_pkg::PINS_RST;
         pin_s1_ff <= '0;
         pin_s2_ff <= '0;
         tck_d_ff <= 1'b0;
      end else begin
         pins_s1_ff <= {tck, tms, tdi, trst_n};
         pins_s2_ff <= pins_s1_ff;
         pin_s1_ff <= pin_in;
         pin_s2_ff <= pin_s1_ff;
         tck_d_ff <= pins_s2_ff.tck;
      end
   end

   assign rise = pins_s2_ff.tck & ~tck_d_ff;
   assign fall = ~pins_s2_ff.tck & tck_d_ff;

   function automatic jid_pkg::jid_tap_t tap_next(input jid_pkg::jid_tap_t s, input logic m);
      case (s)
         jid_pkg::TAP_TLR: tap_next = m ? jid_pkg::TAP_TLR : jid_pkg::TAP_RTI;
         jid_pkg::TAP_RTI: tap_next = m ? jid_pkg::TAP_SDR : jid_pkg::TAP_RTI;
         jid_pkg::TAP_SDR: tap_next = m ? jid_pkg::TAP_SIR : jid_pkg::TAP_CDR;
         jid_pkg::TAP_CDR: tap_next = m ? jid_pkg::TAP_E1DR : jid_pkg::TAP_SHDR;
         jid_pkg::TAP_SHDR: tap_next = m ? jid_pkg::TAP_E1DR : jid_pkg::TAP_SHDR;
         jid_pkg::TAP_E1DR: tap_next = m ? jid_pkg::TAP_UDR : jid_pkg::TAP_PDR;
         jid_pkg::TAP_PDR: tap_next = m ? jid_pkg::TAP_E2DR : jid_pkg::TAP_PDR;
         jid_pkg::TAP_E2DR: tap_next = m ? jid_pkg::TAP_UDR : jid_pkg::TAP_SHDR;
         jid_pkg::TAP_UDR: tap_next = m ? jid_pkg::TAP_SDR : jid_pkg::TAP_RTI;
         jid_pkg::TAP_SIR: tap_next = m ? jid_pkg::TAP_TLR : jid_pkg::TAP_CIR;
         jid_pkg::TAP_CIR: tap_next = m ? jid_pkg::TAP_E1IR : jid_pkg::TAP_SHIR;
         jid_pkg::TAP_SHIR: tap_next = m ? jid_pkg::TAP_E1IR : jid_pkg::TAP_SHIR;
         jid_pkg::TAP_E1IR: tap_next = m ? jid_pkg::TAP_UIR : jid_pkg::TAP_PIR;
         jid_pkg::TAP_PIR: tap_next = m ? jid_pkg::TAP_E2IR : jid_pkg::TAP_PIR;
         jid_pkg::TAP_E2IR: tap_next = m ? jid_pkg::TAP_UIR : jid_pkg::TAP_SHIR;
         jid_pkg::TAP_UIR: tap_next = m ? jid_pkg::TAP_SDR : jid_pkg::TAP_RTI;
         default: tap_next = jid_pkg::TAP_TLR;
      endcase
   endfunction

   jid_pkg::jid_tap_t state_ff, nxt_state;
   logic [jid_pkg::IRW-1:0] ir_sh_ff, nxt_ir_sh, ir_ff, nxt_ir;
   logic byp_ff, nxt_byp;
   logic [jid_pkg::IDW-1:0] id_ff, nxt_id;
   logic [jid_pkg::BSL-1:0] bs_sh_ff, nxt_bs_sh, bs_hold_ff, nxt_bs_hold, bs_cap;
   logic tdo_ff, nxt_tdo, tdo_oe_ff, nxt_tdo_oe;
   jid_pkg::jid_sel_t sel;
   logic test_mode, bs_sel;

   // Only EXTEST and INTEST put the input cells in test mode; SAMPLE keeps system mode
   assign test_mode = (ir_ff == jid_pkg::OP_EXTEST) || (ir_ff == jid_pkg::OP_INTEST);
   assign bs_sel = test_mode || (ir_ff == jid_pkg::OP_SAMPLE);

   always_comb begin
      case (ir_ff)
         jid_pkg::OP_EXTEST, jid_pkg::OP_SAMPLE, jid_pkg::OP_INTEST: sel = jid_pkg::SEL_BS;
         jid_pkg::OP_IDCODE: sel = jid_pkg::SEL_ID;
         default: sel = jid_pkg::SEL_BYP;
      endcase
   end

   // Capture source per cell kind and instruction
   always_comb begin
      bs_cap[jid_pkg::BS_IN +: jid_pkg::NI] = pin_s2_ff;
      bs_cap[jid_pkg::BS_OUT +: jid_pkg::NO] = core_out;
      bs_cap[jid_pkg::BS_EN +: jid_pkg::NO] = core_oe;
      if (ir_ff == jid_pkg::OP_EXTEST) begin
         bs_cap[jid_pkg::BS_OUT +: jid_pkg::NO] = bs_hold_ff[jid_pkg::BS_OUT +: jid_pkg::NO];
         bs_cap[jid_pkg::BS_EN +: jid_pkg::NO] = bs_hold_ff[jid_pkg::BS_EN +: jid_pkg::NO];
      end else if (ir_ff == jid_pkg::OP_INTEST) begin
         // Inverted so a stuck input cell is seen as a capture mismatch
         bs_cap[jid_pkg::BS_IN +: jid_pkg::NI] = ~bs_hold_ff[jid_pkg::BS_IN +: jid_pkg::NI];
      end
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_ir_sh = ir_sh_ff;
      nxt_ir = ir_ff;
      nxt_byp = byp_ff;
      nxt_id = id_ff;
      nxt_bs_sh = bs_sh_ff;
      nxt_bs_hold = bs_hold_ff;
      nxt_tdo = tdo_ff;
      nxt_tdo_oe = tdo_oe_ff;
      if (!pins_s2_ff.trst_n) begin
         nxt_state = jid_pkg::TAP_TLR;
         nxt_ir = jid_pkg::OP_IDCODE;
         nxt_tdo_oe = 1'b0;
      end else if (rise) begin
         nxt_state = tap_next(state_ff, pins_s2_ff.tms);
         case (state_ff)
            jid_pkg::TAP_CIR: nxt_ir_sh = jid_pkg::IR_CAPT;
            jid_pkg::TAP_SHIR: nxt_ir_sh = {pins_s2_ff.tdi, ir_sh_ff[jid_pkg::IRW-1:1]};
            jid_pkg::TAP_CDR: begin
               case (sel)
                  jid_pkg::SEL_BS: nxt_bs_sh = bs_cap;
                  jid_pkg::SEL_ID: nxt_id = ID_VALUE;
                  default: nxt_byp = 1'b0;
               endcase
            end
            jid_pkg::TAP_SHDR: begin
               case (sel)
                  jid_pkg::SEL_BS: nxt_bs_sh = {pins_s2_ff.tdi, bs_sh_ff[jid_pkg::BSL-1:1]};
                  jid_pkg::SEL_ID: nxt_id = {pins_s2_ff.tdi, id_ff[jid_pkg::IDW-1:1]};
                  default: nxt_byp = pins_s2_ff.tdi;
               endcase
            end
            default: begin
            end
         endcase
      end else if (fall) begin
         // Update acts on the falling edge; bypass and ID are left alone
         if (state_ff == jid_pkg::TAP_TLR) begin
            nxt_ir = jid_pkg::OP_IDCODE;
         end
         if (state_ff == jid_pkg::TAP_UIR) begin
            nxt_ir = ir_sh_ff;
         end
         if (state_ff == jid_pkg::TAP_UDR && bs_sel) begin
            nxt_bs_hold = bs_sh_ff;
         end
         nxt_tdo_oe = (state_ff == jid_pkg::TAP_SHIR) || (state_ff == jid_pkg::TAP_SHDR);
         if (state_ff == jid_pkg::TAP_SHIR) begin
            nxt_tdo = ir_sh_ff[0];
         end else if (state_ff == jid_pkg::TAP_SHDR) begin
            case (sel)
               jid_pkg::SEL_BS: nxt_tdo = bs_sh_ff[0];
               jid_pkg::SEL_ID: nxt_tdo = id_ff[0];
               default: nxt_tdo = byp_ff;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_ff <= jid_pkg::TAP_TLR;
         ir_sh_ff <= jid_pkg::IR_CAPT;
         ir_ff <= jid_pkg::OP_IDCODE;
         byp_ff <= 1'b0;
         id_ff <= '0;
         bs_sh_ff <= '0;
         bs_hold_ff <= '0;
         tdo_ff <= 1'b0;
         tdo_oe_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         ir_sh_ff <= nxt_ir_sh;
         ir_ff <= nxt_ir;
         byp_ff <= nxt_byp;
         id_ff <= nxt_id;
         bs_sh_ff <= nxt_bs_sh;
         bs_hold_ff <= nxt_bs_hold;
         tdo_ff <= nxt_tdo;
         tdo_oe_ff <= nxt_tdo_oe;
      end
   end

   assign tdo = tdo_ff;
   assign tdo_oe = tdo_oe_ff;

   // Pad and core multiplexing, registered so outputs leave flops
   logic [jid_pkg::NI-1:0] core_in_ff, nxt_core_in;
   logic [jid_pkg::NO-1:0] pad_out_ff, nxt_pad_out, pad_oe_ff, nxt_pad_oe;

   always_comb begin
      nxt_core_in = test_mode ? bs_hold_ff[jid_pkg::BS_IN +: jid_pkg::NI] : pin_s2_ff;
      case (ir_ff)
         jid_pkg::OP_EXTEST, jid_pkg::OP_INTEST, jid_pkg::OP_CLAMP: begin
            nxt_pad_out = bs_hold_ff[jid_pkg::BS_OUT +: jid_pkg::NO];
            nxt_pad_oe = bs_hold_ff[jid_pkg::BS_EN +: jid_pkg::NO];
         end
         jid_pkg::OP_HIGHZ: begin
            nxt_pad_out = core_out;
            nxt_pad_oe = '0;
         end
         jid_pkg::OP_CLAMPZ: begin
            nxt_pad_out = bs_hold_ff[jid_pkg::BS_OUT +: jid_pkg::NO];
            nxt_pad_oe = '0;
         end
         default: begin
            nxt_pad_out = core_out;
            nxt_pad_oe = core_oe;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         core_in_ff <= '0;
         pad_out_ff <= '0;
         pad_oe_ff <= '0;
      end else begin
         core_in_ff <= nxt_core_in;
         pad_out_ff <= nxt_pad_out;
         pad_oe_ff <= nxt_pad_oe;
      end
   end

   assign core_in = core_in_ff;
   assign pad_out = pad_out_ff;
   assign pad_oe = pad_oe_ff;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence cap_ir_s;
      pins_s2_ff.trst_n && rise && state_ff == jid_pkg::TAP_CIR;
   endsequence
   sequence sh_ir_s;
      pins_s2_ff.trst_n && rise && state_ff == jid_pkg::TAP_SHIR;
   endsequence
   sequence dr_cap_s(jid_pkg::jid_sel_t s);
      pins_s2_ff.trst_n && rise && state_ff == jid_pkg::TAP_CDR && sel == s;
   endsequence

   ir_width_a: assert property (sh_ir_s |=>
      ir_sh_ff == {$past(pins_s2_ff.tdi), $past(ir_sh_ff[3:1])})
      else $error("instruction shift wrong");
   ir_capture_a: assert property (cap_ir_s |=> ir_sh_ff == 4'h1)
      else $error("instruction capture not 0001");
   tdo_edge_a: assert property ($changed(tdo_ff) |-> $past(fall))
      else $error("TDO changed off a falling edge");
   byp_capture_a: assert property (dr_cap_s(jid_pkg::SEL_BYP) |=> !byp_ff)
      else $error("bypass did not capture zero");
   id_capture_a: assert property (dr_cap_s(jid_pkg::SEL_ID) |=> id_ff == ID_VALUE)
      else $error("identification not captured");
   intest_cap_a: assert property (dr_cap_s(jid_pkg::SEL_BS) ##0
      ir_ff == jid_pkg::OP_INTEST |=> bs_sh_ff[3:0] == ~$past(bs_hold_ff[3:0]))
      else $error("inverted input capture wrong");
   bs_update_a: assert property (pins_s2_ff.trst_n && fall && bs_sel
      && state_ff == jid_pkg::TAP_UDR |=> bs_hold_ff == $past(bs_sh_ff))
      else $error("chain update lost");
   test_reset_a: assert property (!pins_s2_ff.trst_n [*2] |-> ir_ff == 4'hE ##1 !test_mode)
      else $error("test reset did not select identification");
   highz_off_a: assert property (ir_ff == 4'h7 && $past(ir_ff) == 4'h7 |-> pad_oe_ff == '0)
      else $error("driver enabled under HIGHZ");
   clampz_data_a: assert property (ir_ff == 4'h9 && $past(ir_ff) == 4'h9 |->
      pad_oe_ff == '0 && pad_out_ff == $past(bs_hold_ff[jid_pkg::BS_OUT +: jid_pkg::NO]))
      else $error("CLAMPZ data or enable wrong");
   sample_pass_a: assert property (ir_ff == 4'h3 && $past(ir_ff) == 4'h3 |->
      core_in_ff == $past(pin_s2_ff) && pad_out_ff == $past(core_out))
      else $error("preload reached pins or core");
endmodule // jid_top
`default_nettype wire

// File: verification/jid_tester.sv
// Behavioural test-port tester that drives the link pins of the instruction decoder.
// Assumes the link clock runs at 125 ns, unrelated in phase to the system clock.
`default_nettype none
module jid_tester (
   // Link pins towards the device
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic trst_n,
   // Serial answer
   input wire logic tdo
);
   timeunit 1ns;
   timeprecision 100ps;

   // Test clock stands low between frames; tms and tdi start high like their pull-ups
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      trst_n = 1'b0;
   end

   // Presents tms and tdi after the fall and takes tdo at the rise
   task automatic clk1(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #62.5 tck = 1'b1;
      q = tdo;
      #62.5 tck = 1'b0;
   endtask

   // Pulses test reset, then walks the controller into Run-Idle
   task automatic test_reset();
      logic q;
      trst_n = 1'b0;
      #200 trst_n = 1'b1;
      #200 clk1(1'b0, 1'b1, q);
   endtask

   // One IR or DR scan from Run-Idle back to Run-Idle, LSB first
   task automatic scan(input bit ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic q;
      dout = '0;
      clk1(1'b1, 1'b1, q);
      if (ir) clk1(1'b1, 1'b1, q);
      clk1(1'b0, 1'b1, q);
      clk1(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++) begin
         clk1(i == n - 1, din[i], q);
         dout[i] = q;
      end
      clk1(1'b1, 1'b1, q);
      clk1(1'b0, 1'b1, q);
   endtask
endmodule // jid_tester
`default_nettype wire

// File: verification/jtag_instruction_decoder_tb_top.sv
// Self-checking bench for the instruction decoder: every opcode with preload,
// capture, shift and update, compared with a behavioural model of the pads.
// Assumes the tester model drives the link pins with hierarchical task calls.
`default_nettype none
module jtag_instruction_decoder_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] ID = 32'h2A5C_0001; // Arbitrary identification value
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   wire logic tck, tms, tdi, trst_n;
   logic tdo, tdo_oe;
   logic [3:0] pin_in = 4'h0, core_out = 4'h0, core_oe = 4'h0;
   logic [3:0] pad_out, pad_oe, core_in;
   int n_mismatch = 0;
   int n_checks = 0;
   logic [3:0] ops[$] = '{4'h0, 4'h3, 4'h5, 4'h7, 4'h9, 4'hC, 4'hE, 4'hF, 4'h2, 4'hA};

   always #5 clk_sys = ~clk_sys;

   jid_top #(.ID_VALUE(ID)) jid_top_inst (.clk_sys(clk_sys), .rst(rst), .tck(tck),
      .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
      .pin_in(pin_in), .pad_out(pad_out), .pad_oe(pad_oe), .core_in(core_in),
      .core_out(core_out), .core_oe(core_oe));

   jid_tester jid_tester_inst (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Pad and core expectations for the current instruction and hold contents
   task automatic pads(input logic [3:0] op, input logic [11:0] h);
      logic [3:0] ei, eo, ee;
      ei = pin_in;
      eo = core_out;
      ee = core_oe;
      case (op)
         jid_pkg::OP_EXTEST, jid_pkg::OP_INTEST: {ee, eo, ei} = h;
         jid_pkg::OP_CLAMP: {ee, eo} = h[11:4];
         jid_pkg::OP_HIGHZ: ee = 4'h0;
         jid_pkg::OP_CLAMPZ: begin
            ee = 4'h0;
            eo = h[7:4];
         end
         default: ;
      endcase
      // Core inputs see the pins three clocks late; look mid-cycle where outputs are settled
      repeat (4) @(negedge clk_sys);
      chk("core_in", {28'h0, ei}, {28'h0, core_in});
      chk("pad_out", {28'h0, eo}, {28'h0, pad_out});
      chk("pad_oe", {28'h0, ee}, {28'h0, pad_oe});
      chk("tdo_oe", 32'h0, {31'h0, tdo_oe});
   endtask

   task automatic load_ir(input logic [3:0] op);
      logic [31:0] q;
      jid_tester_inst.scan(1'b1, 4, {28'h0, op}, q);
      chk("ir_capture", {28'h0, jid_pkg::IR_CAPT}, q);
   endtask

   initial begin
      logic [31:0] q, d, exp;
      logic [11:0] h;
      logic [3:0] op;
      int n;
      void'($urandom(32'hC2BE));
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      jid_tester_inst.test_reset();
      jid_tester_inst.scan(1'b0, 32, $urandom, q);
      chk("idcode_after_reset", ID, q);
      pads(jid_pkg::OP_IDCODE, 12'h0);
      $display("test idcode after reset done");
      foreach (ops[k]) begin
         op = ops[k];
         @(posedge clk_sys);
         pin_in <= 4'($urandom);
         core_out <= 4'($urandom);
         core_oe <= 4'($urandom);
         h = 12'($urandom);
         load_ir(jid_pkg::OP_SAMPLE);
         jid_tester_inst.scan(1'b0, 12, {20'h0, h}, q);
         chk("sample_capture", {20'h0, core_oe, core_out, pin_in}, q);
         pads(jid_pkg::OP_SAMPLE, h);
         load_ir(op);
         pads(op, h);
         d = $urandom;
         n = 4;
         exp = {28'h0, d[2:0], 1'b0};
         case (op)
            jid_pkg::OP_EXTEST: exp = {20'h0, h[11:4], pin_in};
            jid_pkg::OP_SAMPLE: exp = {20'h0, core_oe, core_out, pin_in};
            jid_pkg::OP_INTEST: exp = {20'h0, core_oe, core_out, ~h[3:0]};
            jid_pkg::OP_IDCODE: exp = ID;
            default: ;
         endcase
         if (op == jid_pkg::OP_EXTEST || op == jid_pkg::OP_SAMPLE || op == jid_pkg::OP_INTEST)
            n = 12;
         if (op == jid_pkg::OP_IDCODE)
            n = 32;
         jid_tester_inst.scan(1'b0, n, d, q);
         chk("dr_capture", exp, q);
         if (n == 12)
            h = d[11:0];
         pads(op, h);
         $display("test opcode %h done", op);
      end
      load_ir(jid_pkg::OP_EXTEST);
      jid_tester_inst.test_reset();
      jid_tester_inst.scan(1'b0, 32, $urandom, q);
      chk("idcode_after_trst", ID, q);
      pads(jid_pkg::OP_IDCODE, h);
      $display("test reset test done");
      finish_test();
   end

   initial begin
      #800us;
      n_mismatch++;
      finish_test();
   end
endmodule // jtag_instruction_decoder_tb_top
`default_nettype wire
